/* File: src/tcc_regs.svh */
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH
// Trace buffer depth in records and its pointer width
`define TCC_BUF_DEPTH   32768
`define TCC_PTR_W       15
// Delayed stop count field
`define TCC_DLY_W       16
`define TCC_DLY_MIN     16'h0001
`define TCC_DLY_RST     16'h0000
// Channel and event counts, address width
`define TCC_NUM_CH      4
`define TCC_NUM_EV      8
`define TCC_EV_IDX_W    3
`define TCC_ADDR_W      24
`endif

/* File: src/tcc_pkg.sv */
`include "tcc_regs.svh"
package tcc_pkg;
  typedef enum logic [1:0] {
    TCC_MODE_OFF   = 2'b00,
    TCC_MODE_P2P   = 2'b01,
    TCC_MODE_RANGE = 2'b10,
    TCC_MODE_EVENT = 2'b11
  } tcc_mode_e;
  typedef logic [`TCC_ADDR_W-1:0]   tcc_addr_t;
  typedef logic [`TCC_EV_IDX_W-1:0] tcc_evidx_t;
endpackage

/* File: src/tcc_chan.sv */
`timescale 1ns/1ps
`include "tcc_regs.svh"
module tcc_chan
  import tcc_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Run start and bus cycle
  input  wire logic                   arm_i,
  input  wire logic                   cyc_i,
  input  wire tcc_addr_t              addr_i,
  input  wire logic [`TCC_NUM_EV-1:0] evt_i,
  // Setup
  input  wire tcc_mode_e              mode_i,
  input  wire logic                   cyclic_i,
  input  wire tcc_addr_t              start_addr_i,
  input  wire tcc_addr_t              stop_addr_i,
  input  wire tcc_evidx_t             start_ev_i,
  input  wire tcc_evidx_t             stop_ev_i,
  input  wire tcc_evidx_t             range_ev_i,
  // Capture decision for this bus cycle
  output logic                        cap_o
);
  logic win_q, win_d;
  logic done_q, done_d;
  logic start_hit, stop_hit;

  always_comb begin
    start_hit = 1'b0;
    stop_hit  = 1'b0;
    case (mode_i)
      TCC_MODE_P2P: begin
        start_hit = cyc_i && (addr_i == start_addr_i);
        stop_hit  = cyc_i && (addr_i == stop_addr_i);
      end
      TCC_MODE_EVENT: begin
        start_hit = cyc_i && evt_i[start_ev_i];
        stop_hit  = cyc_i && evt_i[stop_ev_i];
      end
      default: begin
        start_hit = 1'b0;
        stop_hit  = 1'b0;
      end
    endcase
  end

  always_comb begin
    win_d  = win_q;
    done_d = done_q;
    if (arm_i || mode_i == TCC_MODE_OFF || mode_i == TCC_MODE_RANGE) begin
      win_d  = 1'b0;
      done_d = 1'b0;
    end else if (win_q && stop_hit) begin
      win_d  = 1'b0;
      // Without cyclic the window opens once per run
      done_d = !cyclic_i;
    end else if (!win_q && !done_q && start_hit) begin
      win_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      win_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      win_q  <= win_d;
      done_q <= done_d;
    end
  end

  // Start and stop cycles both belong to the window
  always_comb begin
    case (mode_i)
      TCC_MODE_OFF:   cap_o = 1'b0;
      TCC_MODE_RANGE: cap_o = cyc_i && evt_i[range_ev_i];
      // A stop hit while the window is shut records nothing
      default:        cap_o = cyc_i && (win_q || (!done_q && start_hit));
    endcase
  end
endmodule // tcc_chan

/* File: src/tcc_top.sv */
`timescale 1ns/1ps
`include "tcc_regs.svh"
// Operation
// - With immediate stop on, a selected match halts acquisition then.
// - Immediate and delayed stop are enabled apart; in a shared cycle the immediate stop wins.
// - The four range channels act only while free-running trace is off.
// - Each channel is off, point to point, range or event; off is inert.
// - Point to point runs from the start address to the stop address.
// - Cyclic re-arms start and stop so a later start reopens the window.
// - Range mode records only the cycles matching the selected event.
// - Event mode opens on the start event and closes on the stop event.
// - Event mode with cyclic alternates windows while events recur.
// - A clear empties the one shared trace buffer but keeps a record written in the same cycle.
// - Free trace records every cycle from program start to program halt or an earlier stop.
// - The buffer is a 32768-record ring that overwrites the oldest.
module tcc_top
  import tcc_pkg::*;
#(
  parameter int NUM_CH = `TCC_NUM_CH,
  parameter int NUM_EV = `TCC_NUM_EV
) (
  // Clock and reset
  input  wire logic                     REF_CLK_I,
  input  wire logic                     RST_I,
  // Target bus
  input  wire logic                     RUN_I,
  input  wire logic                     BUS_CYC_I,
  input  wire tcc_addr_t                BUS_ADDR_I,
  input  wire logic [NUM_EV-1:0]        EVT_MATCH_I,
  // Stop setup
  input  wire logic                     FREE_EN_I,
  input  wire logic                     STOP_EN_I,
  input  wire logic [NUM_EV-1:0]        STOP_SEL_I,
  input  wire logic                     DSTOP_EN_I,
  input  wire logic [NUM_EV-1:0]        DSTOP_SEL_I,
  input  wire logic [`TCC_DLY_W-1:0]    DELAY_CNT_I,
  // Range channel setup
  input  wire logic [2*NUM_CH-1:0]      CH_MODE_I,
  input  wire logic [NUM_CH-1:0]        CH_CYCLIC_I,
  input  wire tcc_addr_t [NUM_CH-1:0]   CH_START_ADDR_I,
  input  wire tcc_addr_t [NUM_CH-1:0]   CH_STOP_ADDR_I,
  input  wire tcc_evidx_t [NUM_CH-1:0]  CH_START_EV_I,
  input  wire tcc_evidx_t [NUM_CH-1:0]  CH_STOP_EV_I,
  input  wire tcc_evidx_t [NUM_CH-1:0]  CH_RANGE_EV_I,
  // Buffer control
  input  wire logic                     CLEAR_I,
  // Record strobe and buffer state
  output logic                          REC_WE_O,
  output logic [`TCC_PTR_W-1:0]         REC_PTR_O,
  output logic [`TCC_PTR_W:0]           REC_COUNT_O,
  output logic                          ACQ_O,
  output logic                          HALTED_O,
  output logic                          DLY_BUSY_O
);
  logic                  run_q;
  logic                  acq_q, acq_d;
  logic                  halted_q, halted_d;
  logic                  dly_act_q, dly_act_d;
  logic [`TCC_DLY_W-1:0] dly_q, dly_d;
  logic                  we_q, we_d;
  logic [`TCC_PTR_W-1:0] ptr_q, ptr_d;
  logic [`TCC_PTR_W:0]   cnt_q, cnt_d;
  logic                  run_rise, cyc_live, imm_hit, dly_hit, want;
  logic [NUM_CH-1:0]     ch_cap;

  assign run_rise = RUN_I && !run_q;
  assign cyc_live = BUS_CYC_I && acq_q && RUN_I;
  // Match pulses are taken as aligned with the bus cycle
  assign imm_hit  = STOP_EN_I  && |(EVT_MATCH_I & STOP_SEL_I);
  assign dly_hit  = DSTOP_EN_I && |(EVT_MATCH_I & DSTOP_SEL_I);

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      tcc_chan u_chan (
        .clk_i        (REF_CLK_I),
        .rst_i        (RST_I),
        .arm_i        (run_rise),
        .cyc_i        (cyc_live),
        .addr_i       (BUS_ADDR_I),
        .evt_i        (EVT_MATCH_I),
        .mode_i       (tcc_mode_e'(CH_MODE_I[2*g +: 2])),
        .cyclic_i     (CH_CYCLIC_I[g]),
        .start_addr_i (CH_START_ADDR_I[g]),
        .stop_addr_i  (CH_STOP_ADDR_I[g]),
        .start_ev_i   (CH_START_EV_I[g]),
        .stop_ev_i    (CH_STOP_EV_I[g]),
        .range_ev_i   (CH_RANGE_EV_I[g]),
        .cap_o        (ch_cap[g])
      );
    end
  endgenerate

  // Channels are ignored in free trace; free trace takes every cycle
  assign want = FREE_EN_I ? cyc_live
                          : (cyc_live && |ch_cap);

  always_comb begin
    acq_d     = acq_q;
    halted_d  = halted_q;
    dly_act_d = dly_act_q;
    dly_d     = dly_q;
    we_d      = want;
    if (run_rise) begin
      acq_d     = 1'b1;
      halted_d  = 1'b0;
      dly_act_d = 1'b0;
    end else if (!RUN_I) begin
      acq_d     = 1'b0;
      dly_act_d = 1'b0;
    end else if (cyc_live) begin
      // Either stop may end the run first
      if (imm_hit) begin
        acq_d     = 1'b0;
        halted_d  = 1'b1;
        dly_act_d = 1'b0;
      end else if (dly_act_q) begin
        if (dly_q == `TCC_DLY_MIN) begin
          acq_d     = 1'b0;
          halted_d  = 1'b1;
          dly_act_d = 1'b0;
        end
        dly_d = dly_q - `TCC_DLY_MIN;
      end else if (dly_hit) begin
        dly_act_d = 1'b1;
        // A zero count behaves as the least count of one
        dly_d = (DELAY_CNT_I == `TCC_DLY_RST) ? `TCC_DLY_MIN : DELAY_CNT_I;
      end
    end
  end

  // Clear restarts the ring; a record in the same cycle is kept as its first entry
  always_comb begin
    ptr_d = CLEAR_I ? '0 : ptr_q;
    cnt_d = CLEAR_I ? '0 : cnt_q;
    if (we_q) begin
      // Ring pointer wraps, oldest record is overwritten
      ptr_d = ptr_d + `TCC_PTR_W'(1);
      if (cnt_d != (`TCC_PTR_W+1)'(`TCC_BUF_DEPTH)) begin
        cnt_d = cnt_d + (`TCC_PTR_W+1)'(1);
      end
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      run_q     <= 1'b0;
      acq_q     <= 1'b0;
      halted_q  <= 1'b0;
      dly_act_q <= 1'b0;
      dly_q     <= `TCC_DLY_RST;
      we_q      <= 1'b0;
      ptr_q     <= '0;
      cnt_q     <= '0;
    end else begin
      run_q     <= RUN_I;
      acq_q     <= acq_d;
      halted_q  <= halted_d;
      dly_act_q <= dly_act_d;
      dly_q     <= dly_d;
      we_q      <= we_d;
      ptr_q     <= ptr_d;
      cnt_q     <= cnt_d;
    end
  end

  assign REC_WE_O    = we_q;
  assign REC_PTR_O   = ptr_q;
  assign REC_COUNT_O = cnt_q;
  assign ACQ_O       = acq_q;
  assign HALTED_O    = halted_q;
  assign DLY_BUSY_O  = dly_act_q;

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_dly_start;
    cyc_live && !imm_hit && !dly_act_q && dly_hit;
  endsequence

  imm_stop_a: assert property (
    RUN_I && cyc_live && imm_hit
    |=> !acq_q && halted_q && (we_q || !$past(FREE_EN_I))
  ) else $error("immediate stop did not halt after recording");

  imm_wins_a: assert property (
    RUN_I && cyc_live && imm_hit && dly_act_q |=> !dly_act_q && !acq_q
  ) else $error("immediate stop did not override a running delay");

  dly_one_a: assert property (
    (s_dly_start and (RUN_I && DELAY_CNT_I == 16'h0001)) ##1
    (RUN_I && cyc_live && !imm_hit)
    |=> !acq_q && halted_q && (we_q || !$past(FREE_EN_I))
  ) else $error("delay of one cycle did not halt after one record");

  dly_load_a: assert property (
    (s_dly_start and (RUN_I && DELAY_CNT_I > 16'h0001))
    |=> dly_act_q && dly_q == $past(DELAY_CNT_I) && acq_q
  ) else $error("delay counter not loaded on delayed stop match");

  free_all_a: assert property (
    FREE_EN_I && cyc_live |=> we_q
  ) else $error("free trace dropped a live bus cycle");

  chan_ignored_a: assert property (
    !FREE_EN_I && cyc_live && ch_cap == '0 |=> !we_q
  ) else $error("cycle recorded with no channel asking for it");

  no_run_a: assert property (
    !RUN_I |=> !acq_q ##1 !we_q
  ) else $error("acquisition continued after program halt");

  clear_a: assert property (
    CLEAR_I && !we_q |=> REC_COUNT_O == '0 && REC_PTR_O == '0
  ) else $error("clear did not empty the buffer");

  ring_sat_a: assert property (
    !CLEAR_I && we_q && cnt_q == 16'h8000 |=> cnt_q == 16'h8000
      && ptr_q == $past(ptr_q) + 15'h0001
  ) else $error("full ring did not overwrite and hold count");
endmodule // tcc_top

/* File: testbench/tcc_bus_model.sv */
`timescale 1ns/1ps
`include "tcc_regs.svh"
module tcc_bus_model
  import tcc_pkg::*;
(
  // Clock
  input  wire logic                   clk_i,
  // Cycle request from the bench
  input  wire logic                   req_i,
  input  wire tcc_addr_t              addr_i,
  input  wire logic [`TCC_NUM_EV-1:0] evt_i,
  // Target bus and event detectors
  output logic                        cyc_o,
  output tcc_addr_t                   addr_o,
  output logic [`TCC_NUM_EV-1:0]      evt_o
);
  logic                   r;
  tcc_addr_t              a;
  logic [`TCC_NUM_EV-1:0] e;
  initial begin
    cyc_o  = 1'b0;
    addr_o = '0;
    evt_o  = '0;
  end
  // Address is not held between cycles, so idle shows a toggling value
  always @(posedge clk_i) begin
    r = req_i;
    a = addr_i;
    e = evt_i;
    #1;
    cyc_o  = r;
    evt_o  = r ? e : '0;
    addr_o = r ? a : ~addr_o;
  end
endmodule // tcc_bus_model

/* File: testbench/tcc_top_tb.sv */
`timescale 1ns/1ps
`include "tcc_regs.svh"
module tcc_top_tb
  import tcc_pkg::*;
;
  logic clk = 0, rst = 1, run = 0, free = 0, sen = 0, den = 0, clr = 0;
  logic req = 0;
  logic [7:0]  ssel = 0, dsel = 0, evt = 0, mode = 0;
  logic [15:0] dly = 0;
  logic [3:0]  cyc = 0;
  tcc_addr_t   addr = 0, b_addr;
  tcc_addr_t [3:0]  sa, pa;
  tcc_evidx_t [3:0] se, pe, re;
  logic        b_cyc, we, acq, halted, dbusy;
  logic [7:0]  b_evt;
  logic [14:0] ptr;
  logic [15:0] cnt;
  int fails = 0, checks_done = 0, nrec = 0, ncyc = 0, nbusy = 0;
  tcc_mode_e md[6] = '{TCC_MODE_P2P, TCC_MODE_P2P, TCC_MODE_EVENT,
                       TCC_MODE_EVENT, TCC_MODE_RANGE, TCC_MODE_OFF};
  int ex[6] = '{3, 6, 3, 5, 2, 0};
  logic [5:0] cv = 6'h0A;
  logic [63:0] cp = 64'h0002010402000104;

  tcc_bus_model bus_u (.clk_i(clk), .req_i(req), .addr_i(addr),
    .evt_i(evt), .cyc_o(b_cyc), .addr_o(b_addr), .evt_o(b_evt));
  tcc_top dut_u (.REF_CLK_I(clk), .RST_I(rst), .RUN_I(run),
    .BUS_CYC_I(b_cyc), .BUS_ADDR_I(b_addr), .EVT_MATCH_I(b_evt),
    .FREE_EN_I(free), .STOP_EN_I(sen), .STOP_SEL_I(ssel),
    .DSTOP_EN_I(den), .DSTOP_SEL_I(dsel), .DELAY_CNT_I(dly),
    .CH_MODE_I(mode), .CH_CYCLIC_I(cyc), .CH_START_ADDR_I(sa),
    .CH_STOP_ADDR_I(pa), .CH_START_EV_I(se), .CH_STOP_EV_I(pe),
    .CH_RANGE_EV_I(re), .CLEAR_I(clr), .REC_WE_O(we), .REC_PTR_O(ptr),
    .REC_COUNT_O(cnt), .ACQ_O(acq), .HALTED_O(halted),
    .DLY_BUSY_O(dbusy));

  always #5 clk = ~clk;

  // Record strobes counted here; also cuts a hang short
  always @(posedge clk) begin
    ncyc++;
    if (we === 1'b1) nrec++;
    if (dbusy === 1'b1) nbusy++;
    if (ncyc == 40000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string m, input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  // Byte i of evs is the event pattern of bus cycle i
  task automatic run_pat(input logic [63:0] evs, input int n, e_n,
                         input string m);
    int b;
    run = 0;
    tick(1);
    run = 1;
    tick(2);
    b = nrec;
    for (int i = 0; i < n; i++) begin
      req = 1;
      addr = 24'h000100 + 24'(i % 4);
      evt = evs[8*i+:8];
      tick(1);
    end
    req = 0;
    evt = '0;
    tick(4);
    chk(m, 32'(nrec - b), 32'(e_n));
    $display("test %s done", m);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    for (int g = 0; g < 4; g++) begin
      sa[g] = 24'h000101;
      pa[g] = 24'h000103;
      se[g] = 3'h0;
      pe[g] = 3'h1;
      re[g] = 3'h2;
    end
    tick(5);
    rst = 0;
    chk("acq reset", 32'(acq), 32'h0);
    chk("count reset", 32'(cnt), 32'h0);
    free = 1;
    mode = 8'hAA;
    run_pat(64'h0, 5, 5, "free");
    chk("count", 32'(cnt), 32'h5);
    chk("acq on", 32'(acq), 32'h1);
    sen = 1;
    ssel = 8'h04;
    run_pat(64'h0000000000040000, 6, 3, "stop");
    chk("halted", 32'(halted), 32'h1);
    chk("acq off", 32'(acq), 32'h0);
    den = 1;
    dsel = 8'h02;
    dly = 16'h0002;
    run_pat(64'h0000000000000200, 7, 4, "delay");
    chk("halted", 32'(halted), 32'h1);
    chk("busy cycles", 32'(nbusy), 32'h2);
    run_pat(64'h0000000000040200, 6, 3, "both");
    chk("busy cycles", 32'(nbusy), 32'h3);
    dly = 16'h0001;
    run_pat(64'h0000000000000200, 7, 3, "delay one");
    chk("busy cycles", 32'(nbusy), 32'h4);
    free = 0;
    sen = 0;
    den = 0;
    // Channel windows; the bench rotates the row over all four channels
    for (int k = 0; k < 6; k++) begin
      mode = '0;
      cyc = '0;
      mode[2*(k%4)+:2] = md[k];
      cyc[k%4] = cv[k];
      run_pat(cp, 8, ex[k], "chan");
    end
    // Ring starts empty so the wrap point does not hang on earlier tests
    free = 1;
    clr = 1;
    run = 0;
    tick(1);
    clr = 0;
    run = 1;
    tick(2);
    req = 1;
    tick(32770);
    req = 0;
    tick(4);
    chk("ring count", 32'(cnt), 32'h8000);
    chk("ring ptr", 32'(ptr), 32'h2);
    $display("test ring done");
    clr = 1;
    tick(1);
    clr = 0;
    tick(1);
    chk("clear count", 32'(cnt), 32'h0);
    chk("clear ptr", 32'(ptr), 32'h0);
    $display("test clear done");
    end_of_test();
  end
endmodule // tcc_top_tb
